// ===== acc_conv_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "acc_defs.svh"

// Notes on behaviour
// - Single timer mode re-arms only on enable
// - Software start or timer trigger, mode selects
// - Overlapping trigger never stalls later conversions
// - Overlapping trigger sets timing overflow flag
// - Power and enable cycle recovers operation
// - Source code 11 selects subsystem clock
// - Source switch with subsystem off never hangs
// - Divider gives ratios one to eight
// - Four selectable sources feed the divider
// - Master select picks shared reference owner
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int CHANNELS     = 4,
  parameter int SAMPLE_TICKS = 4,
  parameter int CONV_TICKS   = 13,
  parameter int CH_W         = 2
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            module_oscillator,
  input  wire logic            auxiliary_clock,
  input  wire logic            main_clock,
  input  wire logic            subsystem_clock,
  input  wire logic            subsystem_clock_off,
  input  wire logic            timer_trigger,
  input  wire logic            reference_master_select,
  input  wire logic            reference_on,
  input  wire logic            reference_output,
  output logic                 converter_busy,
  output logic                 sample_hold,
  output logic                 conv_done,
  output logic [CH_W-1:0]      conv_channel,
  output logic                 shared_ref_on,
  output logic                 shared_ref_out
);

  localparam int TMR = 5;
  localparam int SOFF = 4;

  // Control and status state.
  logic            enc_reg, enc_next, on_reg, on_next, reference_on_reg, reference_on_next;
  logic [1:0]      seq_reg, seq_next, ssel_reg, ssel_next;
  logic            shp_reg, shp_next, pdiv_reg, pdiv_next, reference_output_reg, reference_output_next;
  logic [2:0]      div_reg, div_next;
  logic            tov_reg, tov_next, armed_reg, armed_next;
  // Pin synchronisers.
  logic [5:0]      s1_reg, s2_reg, s3_reg, stab_reg, stab_next;
  // Conversion engine.
  acc_state_e      st_reg, st_next;
  logic [4:0]      cnt_reg, cnt_next;
  logic [CH_W-1:0] ch_reg, ch_next;
  logic            busy_reg, busy_next, sh_reg, sh_next, done_reg, done_next;
  logic            ron_reg, ron_next, rout_reg, rout_next;
  // Bus slave.
  logic            awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next;
  logic            rv_reg, rv_next, awr_reg, awr_next, wr_reg, wr_next, arr_reg, arr_next;
  logic [7:0]      awa_reg, awa_next;
  logic [31:0]     wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]      ws_reg, ws_next;
  logic [1:0]      br_reg, br_next, rr_reg, rr_next;

  logic [5:0]  pins;
  logic [3:0]  src_edge;
  logic        tmr_edge, src_tick, conv_tick, div_restart;
  logic        do_wr, sw_start, trig, last_ch;
  logic [31:0] wmask, wval;

  assign pins = {timer_trigger, subsystem_clock_off, subsystem_clock, main_clock,
                 auxiliary_clock, module_oscillator};

  // Register view shared by the read path and the byte-lane merge of writes.
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      `ACC_OFF_CTRL0: begin
        v[`ACC_C0_ENC]   = enc_reg;
        v[`ACC_C0_ON]    = on_reg;
        v[`ACC_C0_REFERENCE_ON] = reference_on_reg;
      end
      `ACC_OFF_CTRL1: begin
        v[`ACC_C1_SEQ_HI:`ACC_C1_SEQ_LO]   = seq_reg;
        v[`ACC_C1_SHP]                     = shp_reg;
        v[`ACC_C1_SSEL_HI:`ACC_C1_SSEL_LO] = ssel_reg;
        v[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO]   = div_reg;
        v[`ACC_C1_PDIV]                    = pdiv_reg;
        v[`ACC_C1_REFERENCE_OUTPUT]                  = reference_output_reg;
      end
      `ACC_OFF_STATUS: begin
        v[`ACC_ST_BUSY]                        = busy_reg;
        v[`ACC_ST_TOV]                         = tov_reg;
        v[`ACC_ST_ARMED]                       = armed_reg;
        v[`ACC_ST_CHAN_LO+CH_W-1:`ACC_ST_CHAN_LO] = ch_reg;
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == `ACC_OFF_CTRL0) || (a == `ACC_OFF_CTRL1) ||
           (a == `ACC_OFF_STATUS) || (a == `ACC_OFF_REFCTL);
  endfunction

  // Divider restarts on any second-control write so a source change never
  // leaves a half-counted period waiting on a stopped clock.
  assign src_tick = src_edge[ssel_reg];
  assign div_restart = do_wr && (awa_reg == `ACC_OFF_CTRL1);

  acc_clk_div u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .src_tick  (src_tick),
    .restart   (div_restart),
    .div_code  (div_reg),
    .pdiv_en   (pdiv_reg),
    .conv_tick (conv_tick)
  );

  // All next-state logic: synchronisers, bus slave, control registers, engine.
  always_comb begin
    // Pins count once the second and third stages agree.
    stab_next = stab_reg;
    for (int i = 0; i < 6; i++) begin
      if (s2_reg[i] == s3_reg[i]) stab_next[i] = s3_reg[i];
    end
    src_edge = stab_next[3:0] & ~stab_reg[3:0];
    src_edge[`ACC_SRC_SUBSYS] = src_edge[`ACC_SRC_SUBSYS] & ~stab_reg[SOFF];
    tmr_edge = stab_next[TMR] & ~stab_reg[TMR];

    // Write channel: address and data are taken in either order.
    awh_next = awh_reg;
    wh_next  = wh_reg;
    awa_next = awa_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    if (s_axi_awvalid && awr_reg) begin
      awh_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      wh_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    do_wr = awh_reg && wh_reg && !bv_reg;
    if (do_wr) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = mapped(awa_reg) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    awr_next = !awh_next;
    wr_next  = !wh_next;
    wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    wval  = (rd_word(awa_reg) & ~wmask) | (wd_reg & wmask);

    // Read channel: one read at a time, answered the cycle after address.
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rd_next = rd_word(s_axi_araddr);
      rr_next = mapped(s_axi_araddr) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    arr_next = !rv_next;

    // Control registers.
    enc_next = enc_reg;
    on_next = on_reg;
    reference_on_next = reference_on_reg;
    seq_next = seq_reg;
    shp_next = shp_reg;
    ssel_next = ssel_reg;
    div_next = div_reg;
    pdiv_next = pdiv_reg;
    reference_output_next = reference_output_reg;
    ron_next = ron_reg;
    rout_next = rout_reg;
    sw_start = 1'b0;
    armed_next = armed_reg;
    tov_next = tov_reg;
    if (do_wr) begin
      unique case (awa_reg)
        `ACC_OFF_CTRL0: begin
          // Only an enable rising edge re-arms a timer capture.
          if (wval[`ACC_C0_ENC] && !enc_reg) armed_next = 1'b1;
          enc_next   = wval[`ACC_C0_ENC];
          on_next    = wval[`ACC_C0_ON];
          reference_on_next = wval[`ACC_C0_REFERENCE_ON];
          sw_start   = wd_reg[`ACC_C0_SC] && ws_reg[0];
        end
        `ACC_OFF_CTRL1: begin
          seq_next    = wval[`ACC_C1_SEQ_HI:`ACC_C1_SEQ_LO];
          shp_next    = wval[`ACC_C1_SHP];
          ssel_next   = wval[`ACC_C1_SSEL_HI:`ACC_C1_SSEL_LO];
          div_next    = wval[`ACC_C1_DIV_HI:`ACC_C1_DIV_LO];
          pdiv_next   = wval[`ACC_C1_PDIV];
          reference_output_next = wval[`ACC_C1_REFERENCE_OUTPUT];
        end
        `ACC_OFF_STATUS: begin
          if (wd_reg[`ACC_ST_TOV] && ws_reg[0]) tov_next = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (!on_next || !enc_next) armed_next = 1'b0;

    // Trigger: software start, or a timer edge when pulse mode asks for it.
    trig = on_reg && enc_reg &&
           (shp_reg ? (tmr_edge && (armed_reg || seq_reg != `ACC_SEQ_SINGLE))
                    : sw_start);
    // An overlapping trigger only flags; the running sequence goes on.
    if (trig && busy_reg) tov_next = 1'b1;

    // Conversion engine, stepped by the conversion clock enable.
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    ch_next   = ch_reg;
    busy_next = busy_reg;
    sh_next   = sh_reg;
    done_next = 1'b0;
    last_ch   = (ch_reg == CH_W'(CHANNELS - 1));
    unique case (st_reg)
      ST_IDLE: begin
        if (trig) begin
          st_next   = ST_SAMPLE;
          cnt_next  = 5'h0;
          ch_next   = '0;
          busy_next = 1'b1;
          sh_next   = 1'b1;
          if (seq_reg == `ACC_SEQ_SINGLE && shp_reg) armed_next = 1'b0;
        end
      end
      ST_SAMPLE: begin
        if (conv_tick) begin
          if (cnt_reg == 5'(SAMPLE_TICKS - 1)) begin
            st_next  = ST_CONVERT;
            cnt_next = 5'h0;
            sh_next  = 1'b0;
          end else begin
            cnt_next = cnt_reg + 5'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (conv_tick) begin
          if (cnt_reg == 5'(CONV_TICKS - 1)) begin
            done_next = 1'b1;
            cnt_next  = 5'h0;
            st_next   = ST_IDLE;
            busy_next = 1'b0;
            // Later conversions proceed regardless of any overlapping trigger.
            unique case (seq_reg)
              `ACC_SEQ_SEQ: begin
                if (!last_ch) begin
                  st_next   = ST_SAMPLE;
                  ch_next   = ch_reg + CH_W'(1);
                  busy_next = 1'b1;
                  sh_next   = 1'b1;
                end
              end
              `ACC_SEQ_REP1: begin
                if (enc_reg) begin
                  st_next   = ST_SAMPLE;
                  busy_next = 1'b1;
                  sh_next   = 1'b1;
                end
              end
              `ACC_SEQ_REPSEQ: begin
                if (enc_reg || !last_ch) begin
                  st_next   = ST_SAMPLE;
                  ch_next   = last_ch ? '0 : ch_reg + CH_W'(1);
                  busy_next = 1'b1;
                  sh_next   = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end else begin
            cnt_next = cnt_reg + 5'h1;
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // Powering down abandons everything, so the recovery cycle starts clean.
    if (!on_reg) begin
      st_next   = ST_IDLE;
      busy_next = 1'b0;
      sh_next   = 1'b0;
      cnt_next  = 5'h0;
    end
  end

  // All state registers; reset is synchronous.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {s1_reg, s2_reg, s3_reg, stab_reg} <= '0;
      {enc_reg, on_reg, reference_on_reg, shp_reg, pdiv_reg, reference_output_reg} <= '0;
      {seq_reg, ssel_reg, div_reg} <= '0;
      {tov_reg, armed_reg, busy_reg, sh_reg, done_reg, ron_reg, rout_reg} <= '0;
      st_reg  <= ST_IDLE;
      cnt_reg <= 5'h0;
      ch_reg  <= '0;
      {awh_reg, wh_reg, bv_reg, rv_reg} <= '0;
      {awr_reg, wr_reg, arr_reg} <= '0;
      awa_reg <= 8'h0;
      wd_reg  <= 32'h0;
      ws_reg  <= 4'h0;
      rd_reg  <= 32'h0;
      br_reg  <= 2'h0;
      rr_reg  <= 2'h0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stab_reg <= stab_next;
      enc_reg <= enc_next;
      on_reg <= on_next;
      reference_on_reg <= reference_on_next;
      shp_reg <= shp_next;
      pdiv_reg <= pdiv_next;
      reference_output_reg <= reference_output_next;
      seq_reg <= seq_next;
      ssel_reg <= ssel_next;
      div_reg <= div_next;
      tov_reg <= tov_next;
      armed_reg <= armed_next;
      busy_reg <= busy_next;
      sh_reg <= sh_next;
      done_reg <= done_next;
      // Reference owner chosen by the master select input.
      ron_reg  <= reference_master_select ? reference_on : reference_on_reg;
      rout_reg <= reference_master_select ? reference_output : reference_output_reg;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
      awh_reg <= awh_next;
      wh_reg <= wh_next;
      bv_reg <= bv_next;
      rv_reg <= rv_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      arr_reg <= arr_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      rd_reg <= rd_next;
      br_reg <= br_next;
      rr_reg <= rr_next;
    end
  end

  assign s_axi_awready  = awr_reg;
  assign s_axi_wready   = wr_reg;
  assign s_axi_bvalid   = bv_reg;
  assign s_axi_bresp    = br_reg;
  assign s_axi_arready  = arr_reg;
  assign s_axi_rvalid   = rv_reg;
  assign s_axi_rdata    = rd_reg;
  assign s_axi_rresp    = rr_reg;
  assign converter_busy = busy_reg;
  assign sample_hold    = sh_reg;
  assign conv_done      = done_reg;
  assign conv_channel   = ch_reg;
  assign shared_ref_on  = ron_reg;
  assign shared_ref_out = rout_reg;

endmodule // acc_conv_ctrl
`default_nettype wire

// ===== acc_defs.svh
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register byte offsets.
`define ACC_OFF_CTRL0   8'h00
`define ACC_OFF_CTRL1   8'h04
`define ACC_OFF_STATUS  8'h08
`define ACC_OFF_REFCTL  8'h0c

// First control word fields.
`define ACC_C0_ENC      0
`define ACC_C0_SC       1
`define ACC_C0_ON       2
`define ACC_C0_REFERENCE_ON    3

// Second control word fields.
`define ACC_C1_SEQ_LO   0
`define ACC_C1_SEQ_HI   1
`define ACC_C1_SHP      2
`define ACC_C1_SSEL_LO  4
`define ACC_C1_SSEL_HI  5
`define ACC_C1_DIV_LO   8
`define ACC_C1_DIV_HI   10
`define ACC_C1_PDIV     12
`define ACC_C1_REFERENCE_OUTPUT   16

// Status fields.
`define ACC_ST_BUSY     0
`define ACC_ST_TOV      1
`define ACC_ST_ARMED    2
`define ACC_ST_CHAN_LO  8

// Reference control fields.
`define ACC_RC_MSTR     0
`define ACC_RC_ON       1
`define ACC_RC_OUT      2

// Sequence modes.
`define ACC_SEQ_SINGLE  2'b00
`define ACC_SEQ_SEQ     2'b01
`define ACC_SEQ_REP1    2'b10
`define ACC_SEQ_REPSEQ  2'b11

// Clock source codes.
`define ACC_SRC_MODULE_OSCILLATOR  2'h0
`define ACC_SRC_AUX     2'h1
`define ACC_SRC_MAIN    2'h2
`define ACC_SRC_SUBSYS  2'h3

// Predivider ratio when enabled, as count limit.
`define ACC_PDIV_LAST   2'h3

// AXI responses.
`define ACC_RESP_OKAY   2'b00
`define ACC_RESP_SLVERR 2'b10

`endif

// ===== acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_state_e;
endpackage

// ===== acc_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
`include "acc_defs.svh"

module acc_clk_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       src_tick,
  input  wire logic       restart,
  input  wire logic [2:0] div_code,
  input  wire logic       pdiv_en,
  output logic            conv_tick
);

  logic [1:0] pre_reg, pre_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       tick_reg, tick_next;
  logic       pre_tick;

  // Predivide then divide by div_code+1; a restart clears both counters so any
  // ratio, odd ones included, starts clean on the new source.
  always_comb begin
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    pre_tick  = 1'b0;
    if (restart) begin
      pre_next = 2'h0;
      cnt_next = 3'h0;
    end else if (src_tick) begin
      if (!pdiv_en || pre_reg == `ACC_PDIV_LAST) begin
        pre_next = 2'h0;
        pre_tick = 1'b1;
      end else begin
        pre_next = pre_reg + 2'h1;
      end
      if (pre_tick) begin
        if (cnt_reg >= div_code) begin
          cnt_next  = 3'h0;
          tick_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg  <= 2'h0;
      cnt_reg  <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign conv_tick = tick_reg;

endmodule // acc_clk_div
`default_nettype wire

// ===== acc_conv_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the control block from its ports only.
module acc_conv_ctrl_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        reference_master_select,
  input wire logic        reference_on,
  input wire logic        reference_output,
  input wire logic        converter_busy,
  input wire logic        sample_hold,
  input wire logic        conv_done,
  input wire logic        shared_ref_on,
  input wire logic        shared_ref_out
);
  // All checks share one clock and stay quiet while reset is low.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  done_after_busy_a: assert property (conv_done |-> $past(converter_busy))
    else $error("done pulse without a running conversion");
  done_pulse_a: assert property (conv_done |=> !conv_done)
    else $error("done pulse longer than one cycle");
  sample_in_busy_a: assert property (sample_hold |-> converter_busy)
    else $error("sample phase outside a conversion");
  busy_starts_sample_a: assert property ($rose(converter_busy) |-> sample_hold)
    else $error("conversion did not open with sampling");
  // The first edge after release still sees reset-time inputs, hence the guard.
  ref_master_a: assert property (($past(aresetn) && $past(reference_master_select)) |->
    (shared_ref_on == $past(reference_on)) && (shared_ref_out == $past(reference_output)))
    else $error("shared reference not owned by the reference pins");
  rdata_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=>
    (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read answer dropped or changed before taken");
  bresp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write answer dropped or changed before taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while a read answer is pending");
  read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");

  cover property ($fell(converter_busy));
  cover property (conv_done && converter_busy);
  cover property ($rose(shared_ref_on) && reference_master_select);
endmodule // acc_conv_ctrl_checker

bind acc_conv_ctrl acc_conv_ctrl_checker acc_conv_ctrl_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .reference_master_select(reference_master_select),
  .reference_on(reference_on), .reference_output(reference_output),
  .converter_busy(converter_busy), .sample_hold(sample_hold), .conv_done(conv_done),
  .shared_ref_on(shared_ref_on), .shared_ref_out(shared_ref_out));

`default_nettype wire

// ===== acc_timer_model.sv
`timescale 1ns/100ps
`default_nettype none

// Timer output used as the sample trigger on the far side.
module acc_timer_model (
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output logic             timer_trigger
);
  logic [15:0] cnt_reg;

  // High over the first half of each period, so one rising edge per period.
  always_ff @(posedge aclk) begin
    if (!run) begin
      cnt_reg <= 16'h0000;
      timer_trigger <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == period - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
      timer_trigger <= (cnt_reg < (period >> 1));
    end
  end
endmodule // acc_timer_model

`default_nettype wire

// ===== acc_conv_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acc_defs.svh"

module acc_conv_ctrl_tb_top;
  localparam int NCH = 2;
  localparam int TICKS = 5; // Sample ticks plus conversion ticks set below.
  localparam logic [7:0] C0 = `ACC_OFF_CTRL0, C1 = `ACC_OFF_CTRL1, ST = `ACC_OFF_STATUS;
  localparam logic [1:0] OK = `ACC_RESP_OKAY;
  localparam logic [1:0] ERR = `ACC_RESP_SLVERR;
  logic        aclk, awready, wready, bvalid, arready, rvalid, busy, shold, done, chan;
  logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, t_run = 1'b0, ttrig, ref_q, out_q;
  logic        mosc = 1'b0, aux = 1'b0, mclk = 1'b0, sclk = 1'b0, sclk_off = 1'b0;
  logic        ref_m = 1'b0, ref_on = 1'b0, ref_out = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] t_per = 16'h0050;
  int          error_cnt = 0, n_tests = 0, done_cnt = 0, phase = 0;
  int          pers[4] = '{4, 6, 8, 10};

  acc_conv_ctrl #(.CHANNELS(NCH), .SAMPLE_TICKS(2), .CONV_TICKS(3), .CH_W(1)) acc_conv_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_oscillator(mosc), .auxiliary_clock(aux), .main_clock(mclk),
    .subsystem_clock(sclk), .subsystem_clock_off(sclk_off), .timer_trigger(ttrig),
    .reference_master_select(ref_m), .reference_on(ref_on), .reference_output(ref_out),
    .converter_busy(busy), .sample_hold(shold), .conv_done(done), .conv_channel(chan),
    .shared_ref_on(ref_q), .shared_ref_out(out_q));

  acc_timer_model acc_timer_model_inst (
    .aclk(aclk), .run(t_run), .period(t_per), .timer_trigger(ttrig));

  // System clock at 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Slow sources of periods 4, 6, 8 and 10 cycles, and a count of finished conversions.
  always @(posedge aclk) begin
    phase <= phase + 1;
    mosc <= (phase % 4) < 2;
    aux <= (phase % 6) < 3;
    mclk <= (phase % 8) < 4;
    sclk <= (phase % 10) < 5;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Response ready stands from the request on, so each answer is taken as it shows.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("write response", {1'b1, er}, {bvalid, bresp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                        input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk($sformatf("read data at %h", a), exp, rd & m);
    chk($sformatf("read response at %h", a), {1'b1, er}, {rvalid, rs});
  endtask

  task automatic wait_busy(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && busy !== v; n++) @(posedge aclk);
    chk("converter busy", v, busy);
    idle(1);
  endtask

  task automatic timer_run(input int exp);
    int base;
    base = done_cnt;
    t_run <= 1'b1;
    idle(250);
    t_run <= 1'b0;
    idle(40);
    chk("timer conversions", base + exp, done_cnt);
  endtask

  // The start write lands one tick phase late at most, hence the window.
  task automatic clk_case(input logic [31:0] c1, input int per);
    int n;
    wr(C1, c1, OK);
    wr(C0, 32'h7, OK);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge aclk);
    chk_rng($sformatf("conversion cycles ctl %h", c1), (TICKS - 1) * per, (TICKS + 1) * per + 12, n);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    int base;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(8'(i * 4), 32'hffffffff, 32'h0, OK);
    rd_chk(8'h10, 32'hffffffff, 32'h0, ERR);
    wr(8'h10, 32'h7, ERR);
    rd_chk(C0, 32'hffffffff, 32'h0, OK);
    $display("test registers done");
    base = done_cnt;
    wr(C0, 32'h3, OK);
    idle(20);
    chk("busy while off", 1'b0, busy);
    chk("conversions while off", base, done_cnt);
    wr(C0, 32'h7, OK);
    wr(C0, 32'h7, OK);
    wait_busy(1'b1, 4);
    wr(C0, 32'h0, OK);
    wait_busy(1'b0, 4);
    base = done_cnt;
    wr(C0, 32'h4, OK);
    wr(C0, 32'h5, OK);
    wr(C0, 32'h7, OK);
    wait_busy(1'b0, 500);
    chk("recovered conversion", base + 1, done_cnt);
    rd_chk(ST, 32'h1, 32'h0, OK);
    $display("test manual done");
    for (int m = 1; m < 4; m++) begin
      wr(C1, 32'(m), OK);
      base = done_cnt;
      wr(C0, 32'h5, OK);
      wr(C0, 32'h7, OK);
      wr(C0, 32'h7, OK);
      rd_chk(ST, 32'h3, 32'h3, OK);
      for (int n = 0; n < 3000 && done_cnt < base + NCH; n++) @(posedge aclk);
      chk("later conversions ran", 1, done_cnt >= base + NCH);
      wr(C0, 32'h4, OK);
      wait_busy(1'b0, 1000);
      chk("last channel", (m == 2) ? 0 : NCH - 1, chan);
      wr(ST, 32'h2, OK);
      rd_chk(ST, 32'h7, 32'h0, OK);
    end
    $display("test overlap done");
    wr(C1, 32'h4, OK);
    wr(C0, 32'h4, OK);
    wr(C0, 32'h5, OK);
    rd_chk(ST, 32'h4, 32'h4, OK);
    timer_run(1);
    wr(C0, 32'hd, OK);
    rd_chk(ST, 32'h4, 32'h0, OK);
    timer_run(0);
    wr(C0, 32'hc, OK);
    wr(C0, 32'hd, OK);
    timer_run(1);
    $display("test timer done");
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 8; d++) clk_case((d << 8) | (s << 4), pers[s] * (d + 1));
    clk_case(32'h1000, 16);
    sclk_off <= 1'b1;
    wr(C1, 32'h230, OK);
    wr(C0, 32'h7, OK);
    idle(60);
    wr(C1, 32'h200, OK);
    wait_busy(1'b0, 500);
    sclk_off <= 1'b0;
    $display("test clocks done");
    for (int i = 0; i < 16; i++) begin
      ref_m <= i[0];
      ref_on <= i[1];
      ref_out <= i[2];
      wr(C0, {28'h0, i[3], 3'h0}, OK);
      wr(C1, {15'h0, ~i[3], 16'h0}, OK);
      idle(2);
      chk("shared reference", i[0] ? {i[1], i[2]} : {i[3], ~i[3]}, {ref_q, out_q});
    end
    $display("test reference done");
    stop_test;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
endmodule // acc_conv_ctrl_tb_top

`default_nettype wire
